// ===== rtl/phm_port.sv
// phm_port: 8-bit bidirectional port with peripheral muxing.
// assumes: pin levels and peripheral signals synchronous to clk_i.
//
// The address map and the Wishbone register port are this design's own decisions.
`timescale 1ns/1ps
module phm_port (
	input  wire logic        clk_i,          // 50 MHz clock
	input  wire logic        rst_i,          // sync reset, high
	input  wire logic        wb_cyc_i,       // bus cycle
	input  wire logic        wb_stb_i,       // strobe
	input  wire logic        wb_we_i,        // write
	input  wire logic [7:0]  wb_adr_i,       // byte address
	input  wire logic [3:0]  wb_sel_i,       // byte enables
	input  wire logic [31:0] wb_dat_i,       // write data
	output logic      [31:0] wb_dat_o,       // read data
	output logic             wb_ack_o,       // ack
	input  wire logic [7:0]  pin_i,          // pin levels
	output logic      [7:0]  pin_o,          // pin drive level
	output logic      [7:0]  pin_oe_o,       // pin drive enable
	input  wire logic [3:0]  ccp_en_i,       // compare out active
	input  wire logic [3:0]  ccp_out_i,      // compare out level
	output logic      [3:0]  capture_o,      // capture inputs
	input  wire logic [3:0]  pwm_en_i,       // enh pwm active
	input  wire logic [3:0]  pwm_out_i,      // enh pwm level
	input  wire logic [3:0]  pwm_tri_i,      // enh pwm tri-state
	output logic      [7:0]  analog_sel_o,   // analog channel on
	output logic      [3:0]  cmp_in_o        // comparator inputs
);
	// ****************************************************************
	// register file
	// ****************************************************************
	logic [7:0]  latch_ff;
	logic [7:0]  dir_ff;
	logic [7:0]  an_mid_ff;
	logic [7:0]  an_up_ff;
	logic [7:0]  od_ff;
	logic [31:0] dat_ff;
	logic        take;
	logic        wr;
	logic        ack;

	phm_wb_slave u_bus (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.cyc_i  (wb_cyc_i),
		.stb_i  (wb_stb_i),
		.we_i   (wb_we_i),
		.sel_i  (wb_sel_i[0]),
		.ack_o  (ack),
		.take_o (take),
		.wr_o   (wr)
	);

	wire [7:0] wd      = wb_dat_i[7:0];
	wire hit_level     = wb_adr_i == phm_pkg::PHM_OFS_LEVEL;
	wire hit_latch     = wb_adr_i == phm_pkg::PHM_OFS_LATCH;
	wire hit_dir       = wb_adr_i == phm_pkg::PHM_OFS_DIR;
	wire hit_an_mid    = wb_adr_i == phm_pkg::PHM_OFS_AN_MID;
	wire hit_an_up     = wb_adr_i == phm_pkg::PHM_OFS_AN_UP;
	wire hit_od        = wb_adr_i == phm_pkg::PHM_OFS_OD;
	// a write to the level register lands in the latch, as on a port
	wire wr_latch      = wr & (hit_level | hit_latch);
	wire wr_dir        = wr & hit_dir;
	wire wr_an_mid     = wr & hit_an_mid;
	wire wr_an_up      = wr & hit_an_up;
	wire wr_od         = wr & hit_od;

	// level reads the pin itself, even with analog selected
	wire [7:0] rd_byte =
		  hit_level  ? pin_i
		: hit_latch  ? latch_ff
		: hit_dir    ? dir_ff
		: hit_an_mid ? an_mid_ff
		: hit_an_up  ? an_up_ff
		: hit_od     ? od_ff
		: 8'h00;
	wire [31:0] nxt_dat = take ? {24'h000000, rd_byte} : 32'h00000000;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			latch_ff  <= phm_pkg::PHM_RST_LATCH;
			dir_ff    <= phm_pkg::PHM_RST_DIR;
			an_mid_ff <= phm_pkg::PHM_RST_AN;
			an_up_ff  <= phm_pkg::PHM_RST_AN;
			od_ff     <= phm_pkg::PHM_RST_OD;
			dat_ff    <= 32'h00000000;
		end else begin
			if (wr_latch)  latch_ff  <= wd;
			if (wr_dir)    dir_ff    <= wd;
			if (wr_an_mid) an_mid_ff <= wd;
			if (wr_an_up)  an_up_ff  <= wd;
			if (wr_od)     od_ff     <= wd;
			dat_ff <= nxt_dat;
		end
	end

	assign wb_dat_o = dat_ff;
	assign wb_ack_o = ack;

	// ****************************************************************
	// channel and open-drain bit maps
	// ****************************************************************
	// pins 0..3 carry channels 23..20, pins 4..7 channels 12..15
	localparam int AL = phm_pkg::PHM_AN_LO;
	wire [7:0] an_pin = {
		an_mid_ff[AL+3], an_mid_ff[AL+2],
		an_mid_ff[AL+1], an_mid_ff[AL],
		an_up_ff[AL],    an_up_ff[AL+1],
		an_up_ff[AL+2],  an_up_ff[AL+3]
	};
	// pin 4 belongs to the unit whose bit sits highest
	localparam int OL = phm_pkg::PHM_OD_LO;
	wire [3:0] od_pin = {
		od_ff[OL], od_ff[OL+1], od_ff[OL+2], od_ff[OL+3]
	};

	// ****************************************************************
	// per-pin drive
	// ****************************************************************
	logic [7:0] nxt_out;
	logic [7:0] nxt_oe;
	localparam int PL = phm_pkg::PHM_PERI_LO;

	genvar g;
	generate
		for (g = 0; g < 8; g++) begin : g_pin
			localparam bit PERI = (g >= PL);
			localparam int  K    = PERI ? g - PL : 0;
			phm_pin_cell u_cell (
				.dir_i     (dir_ff[g]),
				.latch_i   (latch_ff[g]),
				.ccp_en_i  (PERI ? ccp_en_i[K] : 1'b0),
				.ccp_out_i (ccp_out_i[K]),
				.od_i      (od_pin[K]),
				.pwm_en_i  (PERI ? pwm_en_i[K] : 1'b0),
				.pwm_out_i (pwm_out_i[K]),
				.pwm_tri_i (pwm_tri_i[K]),
				.out_o     (nxt_out[g]),
				.oe_o      (nxt_oe[g])
			);
		end
	endgenerate

	// capture only sees the pin while it is an input
	wire [3:0] nxt_cap = pin_i[7:4] & dir_ff[7:4];

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pin_o        <= 8'h00;
			pin_oe_o     <= 8'h00;
			capture_o    <= 4'h0;
			cmp_in_o     <= 4'h0;
			analog_sel_o <= phm_pkg::PHM_RST_AN;
		end else begin
			pin_o        <= nxt_out;
			pin_oe_o     <= nxt_oe;
			capture_o    <= nxt_cap;
			cmp_in_o     <= pin_i[7:4];
			analog_sel_o <= an_pin;
		end
	end

	// ****************************************************************
	// checks
	// ****************************************************************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	a_analog_after_reset: assert property (
		$fell(rst_i) |-> analog_sel_o == 8'hFF ##1
			analog_sel_o == $past(an_pin))
		else $error("analog select not default after reset");

	a_plain_pin_drive: assert property (
		$past(rst_i) == 1'b0 |->
			pin_oe_o[3:0] == ~$past(dir_ff[3:0]) &&
			pin_o[3:0] == ($past(latch_ff[3:0]) &
				~$past(dir_ff[3:0])))
		else $error("plain pin drive wrong");

	a_level_readback: assert property (
		take && hit_level |=> wb_ack_o &&
			wb_dat_o[7:0] == $past(pin_i))
		else $error("level read wrong");

	a_analog_keeps_input: assert property (
		take && hit_level && (an_pin != 8'h00) |=>
			wb_dat_o[7:0] == $past(pin_i) &&
			cmp_in_o == $past(pin_i[7:4]))
		else $error("analog select disturbed input");

	a_ccp_overrides: assert property (
		!dir_ff[4] && ccp_en_i[0] && !pwm_en_i[0] && !od_pin[0]
		|=> pin_oe_o[4] && pin_o[4] == $past(ccp_out_i[0]))
		else $error("compare output not on pin");

	a_capture_route: assert property (
		##1 capture_o == ($past(pin_i[7:4]) & $past(dir_ff[7:4])))
		else $error("capture routing wrong");

	a_pwm_drive: assert property (
		!dir_ff[5] && pwm_en_i[1] && !pwm_tri_i[1] |=>
			pin_oe_o[5] && pin_o[5] == $past(pwm_out_i[1]))
		else $error("pwm not driving pin");

	a_pwm_tristate: assert property (
		pwm_en_i[2] && pwm_tri_i[2] |=> !pin_oe_o[6])
		else $error("pwm tri-state ignored");

	a_cmp_any_dir: assert property (
		##1 cmp_in_o == $past(pin_i[7:4]))
		else $error("comparator input wrong");

	a_open_drain: assert property (
		!dir_ff[7] && ccp_en_i[3] && !pwm_en_i[3] && od_pin[3]
		|=> pin_o[7] == 1'b0 &&
			pin_oe_o[7] == !$past(ccp_out_i[3]))
		else $error("open drain drive wrong");

	a_push_pull: assert property (
		!dir_ff[7] && ccp_en_i[3] && !pwm_en_i[3] && !od_pin[3]
		|=> pin_oe_o[7])
		else $error("push-pull not driving");

	// ****************************************************************
	// register, bus and pin drive checks
	// ****************************************************************
	a_ack_after_take: assert property (
		take |=> wb_ack_o)
		else $error("no ack after request");

	a_ack_one_cycle: assert property (
		wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");

	a_idle_data_zero: assert property (
		!wb_ack_o |-> wb_dat_o == 32'h00000000)
		else $error("read data not zero while idle");

	a_latch_write: assert property (
		wr && (hit_level || hit_latch) |=>
			latch_ff == $past(wb_dat_i[7:0]))
		else $error("latch write lost");

	a_latch_holds: assert property (
		!wr_latch |=> latch_ff == $past(latch_ff))
		else $error("latch changed without write");

	a_dir_write: assert property (
		wr && hit_dir |=> dir_ff == $past(wb_dat_i[7:0]))
		else $error("direction write lost");

	a_sel_guard: assert property (
		wr |-> wb_sel_i[0] && wb_we_i && wb_ack_o)
		else $error("write without lane, direction or ack");

	a_analog_mid_write: assert property (
		wr && hit_an_mid |=> an_mid_ff == $past(wb_dat_i[7:0]))
		else $error("analog mid write lost");

	a_analog_up_write: assert property (
		wr && hit_an_up |=> an_up_ff == $past(wb_dat_i[7:0]))
		else $error("analog upper write lost");

	a_analog_pin_map: assert property (
		1'b1 |=> analog_sel_o == {$past(an_mid_ff[7:4]),
			$past(an_up_ff[4]), $past(an_up_ff[5]),
			$past(an_up_ff[6]), $past(an_up_ff[7])})
		else $error("analog channel map wrong");

	a_od_write: assert property (
		wr && hit_od |=> od_ff == $past(wb_dat_i[7:0]))
		else $error("open-drain write lost");

	a_input_no_drive: assert property (
		1'b1 |=> (pin_oe_o & $past(dir_ff)) == 8'h00)
		else $error("input pin driven");

	a_pwm_over_ccp: assert property (
		!dir_ff[6] && pwm_en_i[2] && ccp_en_i[2] && !pwm_tri_i[2]
		|=> pin_oe_o[6] && pin_o[6] == $past(pwm_out_i[2]))
		else $error("compare unit beat enhanced pwm");

	a_pwm_tri_pin4: assert property (
		!dir_ff[4] && pwm_en_i[0] && pwm_tri_i[0] |=> !pin_oe_o[4])
		else $error("pwm tri-state ignored on pin 4");

	a_od_pin4_map: assert property (
		!dir_ff[4] && ccp_en_i[0] && !pwm_en_i[0] && od_ff[6]
		|=> !pin_o[4] && pin_oe_o[4] == !$past(ccp_out_i[0]))
		else $error("open drain on pin 4 wrong");

	a_capture_out_zero: assert property (
		!dir_ff[5] |=> !capture_o[1])
		else $error("capture seen on output pin");

	a_latch_pin6: assert property (
		!dir_ff[6] && !ccp_en_i[2] && !pwm_en_i[2] |=>
			pin_oe_o[6] && pin_o[6] == $past(latch_ff[6]))
		else $error("latch not driving pin 6");

	c_latch_write: cover property (wr_latch ##1 !dir_ff[0]);
	c_ccp_drive: cover property (!dir_ff[4] && ccp_en_i[0]);
	c_pwm_tri: cover property (pwm_en_i[1] && pwm_tri_i[1]);
	c_digital: cover property (wr_an_up ##1 an_up_ff == 8'h00);
	c_open_drain: cover property (!dir_ff[7] && ccp_en_i[3] && od_pin[3]);
endmodule : phm_port

// ===== rtl/phm_pkg.sv
// phm_pkg: constants of the 8-bit port pin multiplexer.
// assumes: 32-bit classic Wishbone, one aligned word per register.
//
// Contract
// - Each pin has its own direction bit; output drives the latch, input reads the pin.
// - After reset every pin is selected as its analog converter input channel.
// - Selecting the analog function leaves the digital input path untouched.
// - With direction 0 a capture/compare unit output overrides the latch; with 1 the pin feeds its capture input.
// - With direction 0 the enhanced PWM output drives the pin, and that unit may force the pin to high impedance.
// - Comparator inputs follow the pin whatever the direction bit says.
package phm_pkg;
	// ****************************************************************
	// register map
	// ****************************************************************
	localparam logic [7:0] PHM_OFS_LEVEL  = 8'h00;
	localparam logic [7:0] PHM_OFS_LATCH  = 8'h04;
	localparam logic [7:0] PHM_OFS_DIR    = 8'h08;
	localparam logic [7:0] PHM_OFS_AN_MID = 8'h0C;
	localparam logic [7:0] PHM_OFS_AN_UP  = 8'h10;
	localparam logic [7:0] PHM_OFS_OD     = 8'h14;

	// ****************************************************************
	// values after reset
	// ****************************************************************
	localparam logic [7:0] PHM_RST_LATCH  = 8'h00;
	localparam logic [7:0] PHM_RST_DIR    = 8'hFF;
	localparam logic [7:0] PHM_RST_AN     = 8'hFF;
	localparam logic [7:0] PHM_RST_OD     = 8'h00;

	// ****************************************************************
	// field positions
	// ****************************************************************
	// peripheral pins are 4..7 of the port
	localparam int PHM_PERI_LO = 4;
	// first of the four analog bits used in each select register
	localparam int PHM_AN_LO   = 4;
	// open-drain bit of the unit on pin 7; pins 6..4 follow upward
	localparam int PHM_OD_LO   = 3;
endpackage : phm_pkg

// ===== rtl/phm_wb_slave.sv
// phm_wb_slave: classic Wishbone handshake for the port registers.
// assumes: master holds the request until it samples ack.
`timescale 1ns/1ps
module phm_wb_slave (
	input  wire logic       clk_i,    // system clock
	input  wire logic       rst_i,    // sync reset, high
	input  wire logic       cyc_i,    // bus cycle
	input  wire logic       stb_i,    // strobe
	input  wire logic       we_i,     // write
	input  wire logic [0:0] sel_i,    // low byte lane
	output logic            ack_o,    // registered ack
	output logic            take_o,   // first cycle of request
	output logic            wr_o      // write commits now
);
	// ****************************************************************
	// handshake
	// ****************************************************************
	logic ack_ff;
	logic nxt_ack;
	wire  req = cyc_i & stb_i;

	// one wait state; ack drops the cycle after it was given
	assign nxt_ack = req & ~ack_ff;
	assign take_o  = nxt_ack;
	// write lands on the edge where the master sees ack
	assign wr_o    = req & ack_ff & we_i & sel_i[0];
	assign ack_o   = ack_ff;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_ff <= 1'b0;
		end else begin
			ack_ff <= nxt_ack;
		end
	end
endmodule : phm_wb_slave

// ===== rtl/phm_pin_cell.sv
// phm_pin_cell: drive selection for one port pin.
// assumes: peripheral enables come from the owning units.
`timescale 1ns/1ps
module phm_pin_cell (
	input  wire logic dir_i,      // 1 = input
	input  wire logic latch_i,    // latch bit
	input  wire logic ccp_en_i,   // compare/pwm output active
	input  wire logic ccp_out_i,  // compare/pwm level
	input  wire logic od_i,       // open-drain select
	input  wire logic pwm_en_i,   // enhanced pwm active
	input  wire logic pwm_out_i,  // enhanced pwm level
	input  wire logic pwm_tri_i,  // enhanced pwm tri-state
	output logic      out_o,      // drive level
	output logic      oe_o        // drive enable
);
	// ****************************************************************
	// priority: enhanced pwm, then compare unit, then latch
	// ****************************************************************
	wire drv     = ~dir_i;
	wire use_pwm = drv & pwm_en_i;
	wire use_ccp = drv & ~pwm_en_i & ccp_en_i;
	wire use_lat = drv & ~pwm_en_i & ~ccp_en_i;

	// open drain only pulls low; a high level releases the pin
	wire ccp_oe  = od_i ? ~ccp_out_i : 1'b1;

	assign oe_o  = (use_pwm & ~pwm_tri_i)
		| (use_ccp & ccp_oe)
		| use_lat;
	assign out_o = use_pwm ? pwm_out_i
		: use_ccp ? (ccp_out_i & ~od_i)
		: (use_lat & latch_i);
endmodule : phm_pin_cell

// ===== bench/phm_pin_model.sv
// phm_pin_model: the package pins as seen from outside the port.
// assumes: a released pin takes the level that the board puts on it.
`timescale 1ns/1ps
module phm_pin_model (
	input  wire logic [7:0] drv_i,  // level from the port
	input  wire logic [7:0] oe_i,   // port drives when high
	input  wire logic [7:0] ext_i,  // board level when released
	output logic      [7:0] pin_o   // level on the pins
);
	// released pins show the board, never the last driven level
	assign pin_o = (oe_i & drv_i) | (~oe_i & ext_i);
endmodule : phm_pin_model

// ===== bench/eight_bit_port_h_pin_mux_test.sv
// eight_bit_port_h_pin_mux_test: corner and random checks of phm_port.
// assumes: pins closed through phm_pin_model, clk_i at 50 MHz.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin \
	n_errors++; $display("wrong value %s exp %h got %h", nm, ex, got); end end
module eight_bit_port_h_pin_mux_test;
	logic        clk_i, rst_i, cyc, stb, we, ack;
	logic [7:0]  adr, pin_i, pin_o, pin_oe, ext, an_o, lvl;
	logic [7:0]  dir, lat, od, mid, up;
	logic [3:0]  sel, ce, co, pe, po, pt, cap, cmp_o;
	logic [31:0] dat_w, dat_r, rd, seed, r1, r2, r3;
	logic [15:0] ex;
	int          n_errors, cmp_count;

	phm_port dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack), .pin_i(pin_i),
		.pin_o(pin_o), .pin_oe_o(pin_oe), .ccp_en_i(ce), .ccp_out_i(co),
		.capture_o(cap), .pwm_en_i(pe), .pwm_out_i(po), .pwm_tri_i(pt),
		.analog_sel_o(an_o), .cmp_in_o(cmp_o));
	phm_pin_model pins (.drv_i(pin_o), .oe_i(pin_oe), .ext_i(ext),
		.pin_o(pin_i));

	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end

	// ****************************************************************
	// helpers
	// ****************************************************************
	function automatic logic [31:0] nxt_rand(input logic [31:0] s);
		return {s[30:0], 1'b0} ^ (s[31] ? 32'h8020_0003 : 32'h0);
	endfunction : nxt_rand

	// priority when driving: enhanced pwm, then compare unit, then latch
	function automatic logic [15:0] exp_pins(input logic [7:0] d, l, o,
		input logic [3:0] c_en, c_out, p_en, p_out, p_tri);
		logic [7:0] v, e;
		v = l & ~d;
		e = ~d;
		for (int k = 0; k < 4; k++) begin
			if (d[k+4]) continue;
			if (p_en[k]) begin
				// level keeps following the unit while tri-stated
				v[k+4] = p_out[k];
				e[k+4] = ~p_tri[k];
			end else if (c_en[k]) begin
				v[k+4] = o[6-k] ? 1'b0 : c_out[k];
				e[k+4] = o[6-k] ? ~c_out[k] : 1'b1;
			end
		end
		return {e, v};
	endfunction : exp_pins

	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] d, input logic [3:0] s);
		int t;
		t = 0;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat_w <= d;
		sel <= s;
		do begin
			@(posedge clk_i);
			t++;
		end while (ack !== 1'b1 && t < 50);
		if (t >= 50) n_errors++;
		rd = dat_r;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : wb

	task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
		wb(1'b0, a, 32'h0, 4'hF);
		`CHK("read data", {24'h0, e}, rd)
	endtask : rdchk

	task automatic summarize;
		$display("checks %0d errors %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : summarize

	// ****************************************************************
	// sequence
	// ****************************************************************
	initial begin
		{rst_i, cyc, stb, we} = 4'b1000;
		{adr, sel, dat_w} = 44'h0;
		{ce, co, pe, po, pt, ext} = 28'h0;
		n_errors = 0;
		cmp_count = 0;
		seed = 32'hB29C;
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		`CHK("analog_sel", 8'hFF, an_o)
		`CHK("pin_oe", 8'h00, pin_oe)
		rdchk(phm_pkg::PHM_OFS_LATCH, phm_pkg::PHM_RST_LATCH);
		rdchk(phm_pkg::PHM_OFS_DIR, phm_pkg::PHM_RST_DIR);
		rdchk(phm_pkg::PHM_OFS_AN_MID, 8'hFF);
		rdchk(phm_pkg::PHM_OFS_AN_UP, 8'hFF);
		rdchk(phm_pkg::PHM_OFS_OD, phm_pkg::PHM_RST_OD);
		wb(1'b1, 8'h18, 32'h5A, 4'hF);
		rdchk(8'h18, 8'h00);
		wb(1'b1, 8'h00, 32'hA5, 4'hE);
		rdchk(phm_pkg::PHM_OFS_LATCH, 8'h00);
		wb(1'b1, 8'h00, 32'h3C, 4'hF);
		rdchk(phm_pkg::PHM_OFS_LATCH, 8'h3C);
		for (int i = 0; i < 40; i++) begin
			seed = nxt_rand(seed);
			r1 = seed;
			seed = nxt_rand(seed);
			r2 = seed;
			seed = nxt_rand(seed);
			r3 = seed;
			{mid, od, lat, dir} = r1;
			// corner: all pins outputs, pins 4..7 under open-drain compare units
			if (i == 0) {dir, od} = 16'h00FF;
			wb(1'b1, phm_pkg::PHM_OFS_DIR, {24'h0, dir}, 4'hF);
			wb(1'b1, phm_pkg::PHM_OFS_LATCH, {24'h0, lat}, 4'hF);
			wb(1'b1, phm_pkg::PHM_OFS_OD, {24'h0, od}, 4'hF);
			wb(1'b1, phm_pkg::PHM_OFS_AN_MID, {24'h0, mid}, 4'hF);
			wb(1'b1, phm_pkg::PHM_OFS_AN_UP, {24'h0, r2[7:0]}, 4'hF);
			ext <= r2[15:8];
			ce <= (i == 0) ? 4'hF : r2[19:16];
			co <= r2[23:20];
			po <= r3[3:0];
			pt <= r3[7:4] & r3[11:8];
			pe <= (i == 0) ? 4'h0 : r3[15:12] & r3[19:16];
			repeat (4) @(posedge clk_i);
			up = {mid[7:4], r2[4], r2[5], r2[6], r2[7]};
			ex = exp_pins(dir, lat, od, ce, co, pe, po, pt);
			lvl = (ex[15:8] & ex[7:0]) | (~ex[15:8] & ext);
			`CHK("pin_o", ex[7:0], pin_o)
			`CHK("pin_oe", ex[15:8], pin_oe)
			`CHK("capture", lvl[7:4] & dir[7:4], cap)
			`CHK("cmp_in", lvl[7:4], cmp_o)
			`CHK("analog", up, an_o)
			rdchk(phm_pkg::PHM_OFS_LEVEL, lvl);
			rdchk(phm_pkg::PHM_OFS_OD, od);
		end
		summarize();
	end

	// a hung handshake must still end the run
	initial begin
		repeat (20000) @(posedge clk_i);
		n_errors++;
		summarize();
	end
endmodule : eight_bit_port_h_pin_mux_test
